// ---- hdl/aidt_defines.vh ----
`ifndef AIDT_DEFINES_VH
`define AIDT_DEFINES_VH
// ==========================================================================
// Operation codes presented to the execution datapath.
`define AIDT_OP_NONE       5'h00
`define AIDT_OP_ADC        5'h01
`define AIDT_OP_INC        5'h02
`define AIDT_OP_SUB        5'h03
`define AIDT_OP_SBB        5'h04
`define AIDT_OP_DEC        5'h05
`define AIDT_OP_NEG        5'h06
`define AIDT_OP_CMP        5'h07
`define AIDT_OP_UMUL       5'h08
`define AIDT_OP_SMUL       5'h09
`define AIDT_OP_SMUL_IMM   5'h0A
`define AIDT_OP_UDIV       5'h0B
`define AIDT_OP_SDIV       5'h0C
`define AIDT_OP_UBCD_ADD   5'h0D
`define AIDT_OP_PBCD_ADD   5'h0E
`define AIDT_OP_UBCD_SUB   5'h0F
`define AIDT_OP_PBCD_SUB   5'h10
`define AIDT_OP_B2W        5'h11
`define AIDT_OP_W2D        5'h12
// ==========================================================================
// Operand forms.
`define AIDT_FORM_NONE     3'h0
`define AIDT_FORM_REG_RM   3'h1
`define AIDT_FORM_IMM_RM   3'h2
`define AIDT_FORM_IMM_ACC  3'h3
`define AIDT_FORM_RM       3'h4
`define AIDT_FORM_REG      3'h5
`define AIDT_FORM_IMPLIED  3'h6
// ==========================================================================
// Opcode byte values and masks.
`define AIDT_MASK_2        8'hFC
`define AIDT_MASK_1        8'hFE
`define AIDT_MASK_5        8'hF8
`define AIDT_PAT_ADC_RM    8'h10
`define AIDT_PAT_ADC_ACC   8'h14
`define AIDT_PAT_SUB_RM    8'h28
`define AIDT_PAT_SBB_RM    8'h18
`define AIDT_PAT_GRP1      8'h80
`define AIDT_PAT_GRP_FE    8'hFE
`define AIDT_PAT_GRP_F6    8'hF6
`define AIDT_PAT_CMP_A     8'h3A
`define AIDT_PAT_CMP_B     8'h38
`define AIDT_PAT_CMP_ACC   8'h3C
`define AIDT_PAT_SIGNED_MULTIPLY_OP_IMM  8'h69
`define AIDT_MASK_SIGNED_MULTIPLY_OP_IMM 8'hFD
`define AIDT_PAT_INC_REG   8'h40
`define AIDT_PAT_DEC_REG   8'h48
`define AIDT_PAT_UBCD_ADD  8'h37
`define AIDT_PAT_PBCD_ADD  8'h27
`define AIDT_PAT_UBCD_SUB  8'h3F
`define AIDT_PAT_PBCD_SUB  8'h2F
`define AIDT_PAT_B2W       8'h98
`define AIDT_PAT_W2D       8'h99
// ==========================================================================
// Reg field sub-codes.
`define AIDT_REG_ADC       3'h2
`define AIDT_REG_SUB       3'h5
`define AIDT_REG_CMP       3'h7
`define AIDT_REG_INC       3'h0
`define AIDT_REG_DEC       3'h1
`define AIDT_REG_NEG       3'h3
`define AIDT_REG_UMUL      3'h4
`define AIDT_REG_SMUL      3'h5
`define AIDT_REG_UDIV      3'h6
`define AIDT_REG_SDIV      3'h7
`define AIDT_MOD_REG       2'h3
// ==========================================================================
// Clock counts.
`define AIDT_CLK_1         6'h01
`define AIDT_CLK_2         6'h02
`define AIDT_CLK_3         6'h03
`define AIDT_CLK_7         6'h07
`define AIDT_CLK_8         6'h08
`define AIDT_CLK_UMUL_RB   6'h0D
`define AIDT_CLK_UMUL_RW   6'h15
`define AIDT_CLK_UMUL_MB   6'h12
`define AIDT_CLK_UMUL_MW   6'h1A
`define AIDT_CLK_SMUL_RB   6'h10
`define AIDT_CLK_SMUL_RW   6'h18
`define AIDT_CLK_SMUL_MB   6'h15
`define AIDT_CLK_SMUL_MW   6'h1D
`define AIDT_CLK_IMMUL_R   6'h17
`define AIDT_CLK_IMMUL_M   6'h1C
`define AIDT_CLK_DIV_RB    6'h12
`define AIDT_CLK_DIV_RW    6'h1A
`define AIDT_CLK_DIV_MB    6'h17
`define AIDT_CLK_DIV_MW    6'h1F
`endif

// ---- hdl/aidt_timing.v ----
`timescale 1ns/10ps
`include "aidt_defines.vh"
// ==========================================================================
// Clock count lookup from operation, width and operand location.
module aidt_timing (
    input  wire [4:0] i_op,      // Decoded operation.
    input  wire       i_word,    // Word width.
    input  wire       i_mem,     // Operand in memory.
    output reg  [5:0] o_clocks   // Clock budget.
);
    // Select register or memory count, then width for the long ops.
    always @* begin
        case (i_op)
            `AIDT_OP_ADC, `AIDT_OP_SUB, `AIDT_OP_SBB, `AIDT_OP_CMP: begin
                o_clocks = i_mem ? `AIDT_CLK_7 : `AIDT_CLK_1;
            end
            `AIDT_OP_INC, `AIDT_OP_DEC, `AIDT_OP_NEG: begin
                o_clocks = i_mem ? `AIDT_CLK_8 : `AIDT_CLK_1;
            end
            `AIDT_OP_UMUL: begin
                o_clocks = i_mem ? (i_word ? `AIDT_CLK_UMUL_MW : `AIDT_CLK_UMUL_MB)
                                 : (i_word ? `AIDT_CLK_UMUL_RW : `AIDT_CLK_UMUL_RB);
            end
            `AIDT_OP_SMUL: begin
                o_clocks = i_mem ? (i_word ? `AIDT_CLK_SMUL_MW : `AIDT_CLK_SMUL_MB)
                                 : (i_word ? `AIDT_CLK_SMUL_RW : `AIDT_CLK_SMUL_RB);
            end
            `AIDT_OP_SMUL_IMM: begin
                o_clocks = i_mem ? `AIDT_CLK_IMMUL_M : `AIDT_CLK_IMMUL_R;
            end
            `AIDT_OP_UDIV, `AIDT_OP_SDIV: begin
                o_clocks = i_mem ? (i_word ? `AIDT_CLK_DIV_MW : `AIDT_CLK_DIV_MB)
                                 : (i_word ? `AIDT_CLK_DIV_RW : `AIDT_CLK_DIV_RB);
            end
            `AIDT_OP_UBCD_ADD, `AIDT_OP_UBCD_SUB: begin
                o_clocks = `AIDT_CLK_3;
            end
            `AIDT_OP_PBCD_ADD, `AIDT_OP_PBCD_SUB, `AIDT_OP_B2W, `AIDT_OP_W2D: begin
                o_clocks = `AIDT_CLK_2;
            end
            default: begin
                o_clocks = 6'h00;
            end
        endcase
    end
endmodule // aidt_timing

// ---- hdl/aidt_decoder.v ----
`timescale 1ns/10ps
`include "aidt_defines.vh"
// Functional notes
// - 000100dw with mod/reg/rm is add-with-carry, 1 register or 7 memory clocks.
// - 100000sw reg 010 adds immediate with carry; 1/8 clocks; second byte if sw=01.
// - 0001010w adds immediate plus carry to accumulator in 1 clock; high byte if w.
// - 1111111w reg 000 increments in 1/8 clocks; 01000rrr increments register in 1.
// - 001010dw with mod/reg/rm subtracts, 1 register or 7 memory clocks.
// - 100000sw reg 101 subtracts immediate, 1 register or 8 memory clocks.
// - 000110dw with mod/reg/rm subtracts with borrow, 1/7 clocks.
// - 1111111w reg 001 decrements in 1/8 clocks; 01001rrr decrements register.
// - Compare writes flags only; 1/7 for reg forms and reg 111; accumulator 1.
// - 1111011w reg 100 unsigned multiply: 13, 21, 18, 26 clocks.
// - 1111011w reg 101 signed multiply: 16, 24, 21, 29 clocks.
// - 011010s1 multiplies by signed immediate, 23/28 clocks; second byte if s=0.
// - 1111011w reg 110 unsigned divide: 18, 26, 23, 31 clocks.
// - 1111011w reg 111 signed divide with the same counts as unsigned divide.
// - 00110111 unpacked BCD add adjust 3 clocks; 00100111 packed 2 clocks.
// - 00111111 unpacked BCD subtract adjust 3 clocks; 00101111 packed 2 clocks.
// - 10011000 byte to word and 10011001 word to double word, 2 clocks each.
// ==========================================================================
// Arithmetic group decoder. Bytes arrive one per valid cycle from fetch.
module aidt_decoder (
    input  wire       i_clk,          // System clock, 250 MHz.
    input  wire       i_reset,        // Synchronous reset, active high.
    input  wire       i_byte_valid,   // Fetch offers a byte.
    input  wire [7:0] i_byte,         // Instruction byte.
    output wire       o_byte_ready,   // Decoder takes the byte.
    input  wire       i_exec_ready,   // Datapath takes the decoded result.
    output reg        o_valid_r,      // Decoded instruction valid.
    output reg  [4:0] o_op_r,         // Operation code.
    output reg  [2:0] o_form_r,       // Operand form.
    output reg        o_word_r,       // Word width.
    output reg        o_dir_reg_r,    // Reg field is destination.
    output reg        o_mem_r,        // Operand in memory.
    output reg  [1:0] o_mod_r,        // Mod field.
    output reg  [2:0] o_reg_r,        // Reg field or register index.
    output reg  [2:0] o_rm_r,         // R/m field.
    output reg        o_flags_only_r, // Result discarded, flags only.
    output reg [15:0] o_imm_r,        // Immediate, extended.
    output reg  [5:0] o_clocks_r,     // Clock budget.
    output reg        o_illegal_r     // First byte, or group reg field, outside this group.
);
    // ======================================================================
    // One-hot states.
    localparam [4:0] ST_OP   = 5'h01;
    localparam [4:0] ST_MODRM = 5'h02;
    localparam [4:0] ST_IMML = 5'h04;
    localparam [4:0] ST_IMMH = 5'h08;
    localparam [4:0] ST_OUT  = 5'h10;

    reg  [4:0] state_r;
    reg  [4:0] state_nxt;
    reg  [7:0] opc_r;
    reg  [4:0] op_r;
    reg  [2:0] form_r;
    reg        imm_two_r;
    reg  [1:0] mod_r;
    reg  [2:0] regf_r;
    reg  [2:0] rm_r;
    reg  [7:0] imm_lo_r;
    reg [15:0] imm_r;
    wire [5:0] clocks;
    wire       is_mem;
    wire       take;

    // Masked opcode compare, used by every pattern test except the exact single-byte opcodes and the opc_r[7:1] compare in ST_MODRM.
    function match;
        input [7:0] b;
        input [7:0] msk;
        input [7:0] pat;
        begin
            match = ((b & msk) == pat);
        end
    endfunction

    // Operation named by the reg field of a group opcode.
    function [4:0] grp_op;
        input [7:0] b;
        input [2:0] r;
        begin
            grp_op = `AIDT_OP_NONE;
            if (match(b, `AIDT_MASK_2, `AIDT_PAT_GRP1)) begin
                case (r)
                    `AIDT_REG_ADC: grp_op = `AIDT_OP_ADC;
                    `AIDT_REG_SUB: grp_op = `AIDT_OP_SUB;
                    `AIDT_REG_CMP: grp_op = `AIDT_OP_CMP;
                    default:       grp_op = `AIDT_OP_NONE;
                endcase
            end else if (match(b, `AIDT_MASK_1, `AIDT_PAT_GRP_FE)) begin
                case (r)
                    `AIDT_REG_INC: grp_op = `AIDT_OP_INC;
                    `AIDT_REG_DEC: grp_op = `AIDT_OP_DEC;
                    default:       grp_op = `AIDT_OP_NONE;
                endcase
            end else if (match(b, `AIDT_MASK_1, `AIDT_PAT_GRP_F6)) begin
                case (r)
                    `AIDT_REG_NEG:  grp_op = `AIDT_OP_NEG;
                    `AIDT_REG_UMUL: grp_op = `AIDT_OP_UMUL;
                    `AIDT_REG_SMUL: grp_op = `AIDT_OP_SMUL;
                    `AIDT_REG_UDIV: grp_op = `AIDT_OP_UDIV;
                    `AIDT_REG_SDIV: grp_op = `AIDT_OP_SDIV;
                    default:        grp_op = `AIDT_OP_NONE;
                endcase
            end else begin
                grp_op = op_r;
            end
        end
    endfunction

    assign take         = i_byte_valid && o_byte_ready;
    assign o_byte_ready = (state_r != ST_OUT);
    assign is_mem       = (mod_r != `AIDT_MOD_REG);

    // Cycle budget lookup.
    aidt_timing u_timing (
        .i_op     (op_r),
        .i_word   (opc_r[0]),
        .i_mem    (is_mem),
        .o_clocks (clocks)
    );

    // Next state from the byte just taken.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OP: begin
                if (take) begin
                    state_nxt = ST_OUT;
                    if (form_of(i_byte) == `AIDT_FORM_IMM_ACC) begin
                        state_nxt = ST_IMML;
                    end else if (form_of(i_byte) == `AIDT_FORM_REG_RM ||
                                 form_of(i_byte) == `AIDT_FORM_IMM_RM ||
                                 form_of(i_byte) == `AIDT_FORM_RM) begin
                        state_nxt = ST_MODRM;
                    end
                end
            end
            ST_MODRM: begin
                if (take) begin
                    state_nxt = ST_OUT;
                    if (form_r == `AIDT_FORM_IMM_RM || op_r == `AIDT_OP_SMUL_IMM)
                        state_nxt = ST_IMML;
                end
            end
            ST_IMML: begin
                if (take) begin
                    state_nxt = imm_two_r ? ST_IMMH : ST_OUT;
                end
            end
            ST_IMMH: begin
                if (take) begin
                    state_nxt = ST_OUT;
                end
            end
            ST_OUT: begin
                if (o_valid_r && i_exec_ready) begin
                    state_nxt = ST_OP;
                end
            end
            default: begin
                state_nxt = ST_OP;
            end
        endcase
    end

    // Operand form of a first byte.
    function [2:0] form_of;
        input [7:0] b;
        begin
            if (match(b, `AIDT_MASK_2, `AIDT_PAT_ADC_RM) ||
                match(b, `AIDT_MASK_2, `AIDT_PAT_SUB_RM) ||
                match(b, `AIDT_MASK_2, `AIDT_PAT_SBB_RM) ||
                match(b, `AIDT_MASK_1, `AIDT_PAT_CMP_A) ||
                match(b, `AIDT_MASK_1, `AIDT_PAT_CMP_B) ||
                match(b, `AIDT_MASK_SIGNED_MULTIPLY_OP_IMM, `AIDT_PAT_SIGNED_MULTIPLY_OP_IMM))
                form_of = `AIDT_FORM_REG_RM;
            else if (match(b, `AIDT_MASK_2, `AIDT_PAT_GRP1))
                form_of = `AIDT_FORM_IMM_RM;
            else if (match(b, `AIDT_MASK_1, `AIDT_PAT_ADC_ACC) ||
                     match(b, `AIDT_MASK_1, `AIDT_PAT_CMP_ACC))
                form_of = `AIDT_FORM_IMM_ACC;
            else if (match(b, `AIDT_MASK_1, `AIDT_PAT_GRP_FE) ||
                     match(b, `AIDT_MASK_1, `AIDT_PAT_GRP_F6))
                form_of = `AIDT_FORM_RM;
            else if (match(b, `AIDT_MASK_5, `AIDT_PAT_INC_REG) ||
                     match(b, `AIDT_MASK_5, `AIDT_PAT_DEC_REG))
                form_of = `AIDT_FORM_REG;
            else if (b == `AIDT_PAT_UBCD_ADD || b == `AIDT_PAT_PBCD_ADD ||
                     b == `AIDT_PAT_UBCD_SUB || b == `AIDT_PAT_PBCD_SUB ||
                     b == `AIDT_PAT_B2W || b == `AIDT_PAT_W2D)
                form_of = `AIDT_FORM_IMPLIED;
            else
                form_of = `AIDT_FORM_NONE;
        end
    endfunction

    // Operation of a first byte, group opcodes resolved later.
    function [4:0] op_of;
        input [7:0] b;
        begin
            if (match(b, `AIDT_MASK_2, `AIDT_PAT_ADC_RM) ||
                match(b, `AIDT_MASK_1, `AIDT_PAT_ADC_ACC))
                op_of = `AIDT_OP_ADC;
            else if (match(b, `AIDT_MASK_2, `AIDT_PAT_SUB_RM))
                op_of = `AIDT_OP_SUB;
            else if (match(b, `AIDT_MASK_2, `AIDT_PAT_SBB_RM))
                op_of = `AIDT_OP_SBB;
            else if (match(b, `AIDT_MASK_1, `AIDT_PAT_CMP_A) ||
                     match(b, `AIDT_MASK_1, `AIDT_PAT_CMP_B) ||
                     match(b, `AIDT_MASK_1, `AIDT_PAT_CMP_ACC))
                op_of = `AIDT_OP_CMP;
            else if (match(b, `AIDT_MASK_SIGNED_MULTIPLY_OP_IMM, `AIDT_PAT_SIGNED_MULTIPLY_OP_IMM))
                op_of = `AIDT_OP_SMUL_IMM;
            else if (match(b, `AIDT_MASK_5, `AIDT_PAT_INC_REG))
                op_of = `AIDT_OP_INC;
            else if (match(b, `AIDT_MASK_5, `AIDT_PAT_DEC_REG))
                op_of = `AIDT_OP_DEC;
            else if (b == `AIDT_PAT_UBCD_ADD)
                op_of = `AIDT_OP_UBCD_ADD;
            else if (b == `AIDT_PAT_PBCD_ADD)
                op_of = `AIDT_OP_PBCD_ADD;
            else if (b == `AIDT_PAT_UBCD_SUB)
                op_of = `AIDT_OP_UBCD_SUB;
            else if (b == `AIDT_PAT_PBCD_SUB)
                op_of = `AIDT_OP_PBCD_SUB;
            else if (b == `AIDT_PAT_B2W)
                op_of = `AIDT_OP_B2W;
            else if (b == `AIDT_PAT_W2D)
                op_of = `AIDT_OP_W2D;
            else
                op_of = `AIDT_OP_NONE;
        end
    endfunction

    // Capture opcode, mod/reg/rm and immediate bytes.
    always @(posedge i_clk) begin
        if (i_reset) begin
            state_r   <= ST_OP;
            opc_r     <= 8'h00;
            op_r      <= `AIDT_OP_NONE;
            form_r    <= `AIDT_FORM_NONE;
            imm_two_r <= 1'b0;
            mod_r     <= `AIDT_MOD_REG;
            regf_r    <= 3'h0;
            rm_r      <= 3'h0;
            imm_lo_r  <= 8'h00;
            imm_r     <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                case (state_r)
                    ST_OP: begin
                        opc_r    <= i_byte;
                        op_r     <= op_of(i_byte);
                        form_r   <= form_of(i_byte);
                        mod_r    <= `AIDT_MOD_REG;
                        regf_r   <= i_byte[2:0];
                        rm_r     <= 3'h0;
                        imm_r    <= 16'h0000;
                        if (match(i_byte, `AIDT_MASK_SIGNED_MULTIPLY_OP_IMM, `AIDT_PAT_SIGNED_MULTIPLY_OP_IMM))
                            imm_two_r <= ~i_byte[1];
                        else if (match(i_byte, `AIDT_MASK_2, `AIDT_PAT_GRP1))
                            imm_two_r <= (i_byte[1:0] == 2'h1);
                        else
                            imm_two_r <= i_byte[0];
                    end
                    ST_MODRM: begin
                        mod_r  <= i_byte[7:6];
                        regf_r <= i_byte[5:3];
                        rm_r   <= i_byte[2:0];
                        op_r   <= grp_op(opc_r, i_byte[5:3]);
                        if (opc_r[7:1] == 7'h34 && op_of(opc_r) == `AIDT_OP_SMUL_IMM)
                            imm_two_r <= ~opc_r[1];
                    end
                    ST_IMML: begin
                        imm_lo_r <= i_byte;
                        imm_r    <= {{8{i_byte[7]}}, i_byte};
                    end
                    ST_IMMH: begin
                        imm_r <= {i_byte, imm_lo_r};
                    end
                    default: begin
                        imm_r <= imm_r;
                    end
                endcase
            end
        end
    end

    // Present the decoded instruction and hold it until the datapath takes it.
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_valid_r      <= 1'b0;
            o_op_r         <= `AIDT_OP_NONE;
            o_form_r       <= `AIDT_FORM_NONE;
            o_word_r       <= 1'b0;
            o_dir_reg_r    <= 1'b0;
            o_mem_r        <= 1'b0;
            o_mod_r        <= 2'h0;
            o_reg_r        <= 3'h0;
            o_rm_r         <= 3'h0;
            o_flags_only_r <= 1'b0;
            o_imm_r        <= 16'h0000;
            o_clocks_r     <= 6'h00;
            o_illegal_r    <= 1'b0;
        end else if (state_r == ST_OUT && !o_valid_r) begin
            o_valid_r      <= 1'b1;
            o_op_r         <= op_r;
            o_form_r       <= form_r;
            o_word_r       <= opc_r[0];
            o_dir_reg_r    <= opc_r[1];
            o_mem_r        <= is_mem;
            o_mod_r        <= mod_r;
            o_reg_r        <= regf_r;
            o_rm_r         <= rm_r;
            o_flags_only_r <= (op_r == `AIDT_OP_CMP);
            o_imm_r        <= imm_r;
            o_clocks_r     <= clocks;
            if (form_r == `AIDT_FORM_IMM_RM && op_r != `AIDT_OP_CMP && clocks == `AIDT_CLK_7)
                o_clocks_r <= `AIDT_CLK_8;
            o_illegal_r    <= (op_r == `AIDT_OP_NONE);
        end else if (o_valid_r && i_exec_ready) begin
            o_valid_r <= 1'b0;
        end
    end
endmodule // aidt_decoder

// ---- bench/aidt_assertions.sv ----
`timescale 1ns/10ps
`include "aidt_defines.vh"
// ======
// Port checks on the arithmetic decoder.
module aidt_checker (
    input wire logic       i_clk,          // System clock.
    input wire logic       i_reset,        // Synchronous reset.
    input wire logic       i_byte_valid,   // Byte offered.
    input wire logic [7:0] i_byte,         // Instruction byte.
    input wire logic       i_exec_ready,   // Datapath accepts.
    input wire logic       o_byte_ready,   // Byte taken.
    input wire logic       o_valid_r,      // Result valid.
    input wire logic [4:0] o_op_r,         // Operation.
    input wire logic [2:0] o_form_r,       // Operand form.
    input wire logic       o_word_r,       // Word width.
    input wire logic       o_mem_r,        // Memory operand.
    input wire logic [1:0] o_mod_r,        // Mod field.
    input wire logic       o_flags_only_r, // Flags only.
    input wire logic [5:0] o_clocks_r      // Clock budget.
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Handover of a result and the return of fetch.
    sequence s_accept;
        o_valid_r && i_exec_ready;
    endsequence
    sequence s_first_ext;
        s_accept ##1 (i_byte_valid && i_byte == 8'h98);
    endsequence
    a_reset_clear: assert property (disable iff (1'b0) i_reset |=> !o_valid_r && o_clocks_r == 6'h00)
        else $error("reset left a result");
    a_accept_drop: assert property (s_accept |=> !o_valid_r && o_byte_ready)
        else $error("result not retired");
    a_hold_stable: assert property (o_valid_r && !i_exec_ready |=>
        o_valid_r && $stable(o_op_r) && $stable(o_clocks_r)) else $error("result moved");
    a_ready_out: assert property (o_valid_r |-> !o_byte_ready) else $error("byte taken early");
    a_ext_answer: assert property (s_first_ext |=> !o_byte_ready ##1 o_valid_r &&
        o_op_r == `AIDT_OP_B2W && o_clocks_r == 6'h02) else $error("extend answer wrong");
    a_adc_clocks: assert property (o_valid_r && o_op_r == `AIDT_OP_ADC &&
        o_form_r == `AIDT_FORM_REG_RM |-> o_clocks_r == (o_mem_r ? 6'h07 : 6'h01))
        else $error("carry add budget wrong");
    a_cmp_flags: assert property (o_valid_r && o_op_r == `AIDT_OP_CMP |->
        o_flags_only_r && o_clocks_r == (o_mem_r ? 6'h07 : 6'h01)) else $error("compare wrong");
    a_mul_clocks: assert property (o_valid_r && o_op_r == `AIDT_OP_UMUL |->
        o_clocks_r == (o_mem_r ? (o_word_r ? 6'h1A : 6'h12) : (o_word_r ? 6'h15 : 6'h0D)))
        else $error("multiply budget wrong");
    a_div_clocks: assert property (o_valid_r &&
        o_op_r inside {`AIDT_OP_UDIV, `AIDT_OP_SDIV} |->
        o_clocks_r == (o_mem_r ? (o_word_r ? 6'h1F : 6'h17) : (o_word_r ? 6'h1A : 6'h12)))
        else $error("divide budget wrong");
    a_mem_mod: assert property (o_valid_r && o_form_r == `AIDT_FORM_REG_RM |->
        o_mem_r == (o_mod_r != 2'h3)) else $error("memory flag wrong");
endmodule // aidt_checker

bind aidt_decoder aidt_checker u_chk (.i_clk(i_clk), .i_reset(i_reset),
    .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_exec_ready(i_exec_ready),
    .o_byte_ready(o_byte_ready), .o_valid_r(o_valid_r), .o_op_r(o_op_r), .o_form_r(o_form_r),
    .o_word_r(o_word_r), .o_mem_r(o_mem_r), .o_mod_r(o_mod_r),
    .o_flags_only_r(o_flags_only_r), .o_clocks_r(o_clocks_r));

// ---- bench/aidt_partner.sv ----
`timescale 1ns/10ps
// ======
// Datapath model: takes results promptly, or with random stalls.
module aidt_partner (
    input  wire logic i_clk,       // System clock.
    input  wire logic i_slow,      // Stall often when high.
    output logic      o_exec_ready // Result accepted.
);
    // Ready changes just after each rising edge.
    initial o_exec_ready = 1'b0;
    always @(posedge i_clk) begin
        #1;
        o_exec_ready = !i_slow || ($urandom_range(3, 0) == 0);
    end
endmodule // aidt_partner

// ---- bench/arith_instr_decode_timing_tb.sv ----
`timescale 1ns/10ps
`include "aidt_defines.vh"
// ======
// Decoder bench: fetch driver, datapath model and result scoreboard.
module arith_instr_decode_timing_tb;
    logic        i_clk, i_reset, i_byte_valid, i_exec_ready, slow;
    logic        o_byte_ready, o_valid_r, o_flags_only_r;
    logic [7:0]  i_byte;
    logic [4:0]  o_op_r;
    logic [5:0]  o_clocks_r;
    logic [15:0] o_imm_r;
    logic [27:0] q[$];
    int          fail_count, tests_run;
    logic [5:0]  ckv[16] = '{6'h0D, 6'h15, 6'h12, 6'h1A, 6'h10, 6'h18, 6'h15, 6'h1D,
                             6'h12, 6'h1A, 6'h17, 6'h1F, 6'h12, 6'h1A, 6'h17, 6'h1F};
    logic [4:0]  opv[4] = '{`AIDT_OP_UMUL, `AIDT_OP_SMUL, `AIDT_OP_UDIV, `AIDT_OP_SDIV};
    aidt_decoder u_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
        .o_byte_ready(o_byte_ready), .i_exec_ready(i_exec_ready), .o_valid_r(o_valid_r),
        .o_op_r(o_op_r), .o_form_r(), .o_word_r(), .o_dir_reg_r(), .o_mem_r(), .o_mod_r(),
        .o_reg_r(), .o_rm_r(), .o_flags_only_r(o_flags_only_r), .o_imm_r(o_imm_r),
        .o_clocks_r(o_clocks_r), .o_illegal_r());
    aidt_partner u_dp (.i_clk(i_clk), .i_slow(slow), .o_exec_ready(i_exec_ready));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Offers one instruction byte by byte and notes the expected result.
    task automatic t(input int n, input logic [31:0] b, input logic [4:0] op,
                     input logic [5:0] c, input logic [15:0] im = 16'h0000);
        int k;
        q.push_back({op, c, im, op == `AIDT_OP_CMP});
        for (int i = n - 1; i >= 0; i--) begin
            i_byte = b[8*i+:8];
            i_byte_valid = 1'b1;
            k = 0;
            do begin
                @(posedge i_clk);
                k++;
            end while (o_byte_ready !== 1'b1 && k < 200);
            if (k >= 200) begin
                fail_count++;
                close_out();
            end
            #1;
            if ($urandom_range(1, 0) == 1) begin
                i_byte_valid = 1'b0;
                i_byte = ~i_byte;
                @(posedge i_clk);
                #1;
            end
        end
    endtask
    // Takes the oldest note whenever a result is handed over.
    always @(posedge i_clk) begin
        if (i_reset === 1'b0 && o_valid_r === 1'b1 && i_exec_ready === 1'b1) begin
            if (q.size() == 0)
                chk(28'h0000000, 28'hFFFFFFF);
            else
                chk({o_op_r, o_clocks_r, o_imm_r, o_flags_only_r}, q.pop_front());
            $display("checked op %h", o_op_r);
        end
    end
    // Free-running system clock.
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // Reset, then every form of the group, with a prompt and a stalling datapath.
    initial begin
        i_reset = 1'b1;
        i_byte_valid = 1'b0;
        i_byte = 8'h00;
        slow = 1'b0;
        void'($urandom(32'hE7547FD8));
        repeat (12) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        chk({20'h00000, o_valid_r, o_byte_ready, o_clocks_r}, 28'h0000040);
        for (int p = 0; p < 2; p++) begin
            slow = p[0];
            t(2, 32'h10C0, `AIDT_OP_ADC, 6'h01);
            t(2, 32'h1300, `AIDT_OP_ADC, 6'h07);
            t(4, 32'h81D03412, `AIDT_OP_ADC, 6'h01, 16'h1234);
            t(3, 32'h8310FE, `AIDT_OP_ADC, 6'h08, 16'hFFFE);
            t(3, 32'h157856, `AIDT_OP_ADC, 6'h01, 16'h5678);
            t(2, 32'h1480, `AIDT_OP_ADC, 6'h01, 16'hFF80);
            t(2, 32'hFFC1, `AIDT_OP_INC, 6'h01);
            t(2, 32'hFE00, `AIDT_OP_INC, 6'h08);
            t(1, 32'h40 | $urandom_range(7, 0), `AIDT_OP_INC, 6'h01);
            t(2, 32'h2AC3, `AIDT_OP_SUB, 6'h01);
            t(2, 32'h2907, `AIDT_OP_SUB, 6'h07);
            t(3, 32'h80EB05, `AIDT_OP_SUB, 6'h01, 16'h0005);
            t(4, 32'h81280001, `AIDT_OP_SUB, 6'h08, 16'h0100);
            t(2, 32'h1BD9, `AIDT_OP_SBB, 6'h01);
            t(2, 32'h1801, `AIDT_OP_SBB, 6'h07);
            t(2, 32'hFFC9, `AIDT_OP_DEC, 6'h01);
            t(2, 32'hFE08, `AIDT_OP_DEC, 6'h08);
            t(2, 32'hF6D8, `AIDT_OP_NEG, 6'h01);
            t(2, 32'h3BC0, `AIDT_OP_CMP, 6'h01);
            t(2, 32'h3800, `AIDT_OP_CMP, 6'h07);
            t(3, 32'h83F801, `AIDT_OP_CMP, 6'h01, 16'h0001);
            t(3, 32'h803805, `AIDT_OP_CMP, 6'h07, 16'h0005);
            t(3, 32'h3D0080, `AIDT_OP_CMP, 6'h01, 16'h8000);
            for (int g = 0; g < 16; g++)
                t(2, {16'h0000, 7'h7B, g[0], ~g[1], ~g[1], 1'b1, g[3:2], 3'h0}, opv[g[3:2]],
                  ckv[g]);
            t(4, 32'h69C00201, `AIDT_OP_SMUL_IMM, 6'h17, 16'h0102);
            t(3, 32'h6B00FF, `AIDT_OP_SMUL_IMM, 6'h1C, 16'hFFFF);
            t(1, 32'h37, `AIDT_OP_UBCD_ADD, 6'h03);
            t(1, 32'h27, `AIDT_OP_PBCD_ADD, 6'h02);
            t(1, 32'h3F, `AIDT_OP_UBCD_SUB, 6'h03);
            t(1, 32'h2F, `AIDT_OP_PBCD_SUB, 6'h02);
            t(1, 32'h98, `AIDT_OP_B2W, 6'h02);
            t(1, 32'h99, `AIDT_OP_W2D, 6'h02);
        end
        i_byte_valid = 1'b0;
        for (int k = 0; k < 200 && q.size() > 0; k++)
            @(posedge i_clk);
        if (q.size() != 0)
            fail_count++;
        close_out();
    end
endmodule // arith_instr_decode_timing_tb
